// *** hdl/sdp_pkg.sv ***
// Purpose: shared constants of the serial converter input port
// Assumes: 32-bit classic wishbone register bus, word-aligned offsets
// Notes:   one frame carries sixteen bits, the low twelve are the code

// ============================================================
// package
// ============================================================
package sdp_pkg;

    // ============================================================
    // link word layout
    // ============================================================
    localparam int          WORD_BITS     = 16;          // bits per frame
    localparam int          CODE_BITS     = 12;          // bits kept for the latch
    localparam int          COUNT_BITS    = 5;           // edge counter width
    localparam logic [4:0]  LAST_EDGE     = 5'h0f;       // index of the sixteenth edge
    localparam logic [4:0]  EDGES_DONE    = 5'h10;       // gate closed after this count
    localparam logic [11:0] CODE_MSB_FLIP = 12'h800;     // msb inversion mask
    localparam logic [11:0] CODE_ZERO     = 12'h000;     // latch value after clear

    // ============================================================
    // register offsets (byte addresses)
    // ============================================================
    localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_LATCH    = 8'h08;
    localparam logic [7:0]  ADDR_CODE     = 8'h0c;

    // ============================================================
    // field positions
    // ============================================================
    localparam int          CTRL_BIPOLAR  = 0;           // range is bipolar
    localparam int          CTRL_CLEAR    = 1;           // write 1: zero the latch
    localparam int          STAT_AUTO     = 0;           // last frame chose auto update
    localparam int          STAT_PENDING  = 1;           // word waits for latch load
    localparam int          STAT_FORMAT   = 2;           // synchronised format pin
    localparam int          STAT_LOAD_N   = 3;           // synchronised latch load pin
    localparam int          STAT_ZERO_N   = 4;           // synchronised clear pin

    // ============================================================
    // reset values
    // ============================================================
    localparam logic        RST_BIPOLAR   = 1'b0;
    localparam logic [11:0] RST_LATCH     = 12'h000;

    // update source state
    typedef enum logic [1:0] {
        SDP_IDLE    = 2'b00,
        SDP_WAITING = 2'b01
    } sdp_upd_type;

endpackage : sdp_pkg

// *** hdl/sdp_link_shift.sv ***
// Purpose: link-side shift register and edge gating on the shift clock
// Assumes: data valid at falling shift clock edges, frame active low
// Notes:   clock may stop outside frames; frame high resets the gate

`timescale 1ns/100ps

module sdp_link_shift
    import sdp_pkg::*;
(
    input  wire logic                 shift_clk,
    input  wire logic                 frame_n,
    input  wire logic                 serial_in,
    input  wire logic                 latch_load_n,
    output logic [CODE_BITS-1:0]      word_hold,
    output logic                      word_auto,
    output logic                      word_toggle
);

    logic [COUNT_BITS-1:0] edge_count;
    logic [WORD_BITS-2:0]  shift_reg;
    logic                  gate_open;
    logic                  last_edge;
    logic                  mode_auto;

    // ============================================================
    // gating
    // ============================================================
    // only sixteen edges per frame are admitted
    assign gate_open = (edge_count != EDGES_DONE);              // [R13]
    assign last_edge = (edge_count == LAST_EDGE);               // [R4]

    // edge counter, held at zero while the frame is inactive
    always_ff @(negedge shift_clk or posedge frame_n) begin
        if (frame_n) begin
            edge_count <= '0;
        end else if (gate_open) begin
            edge_count <= edge_count + 5'h01;                   // [R13]
        end
    end

    // serial bits enter on the falling edge, first bits drop out
    always_ff @(negedge shift_clk) begin
        if (!frame_n && gate_open) begin
            shift_reg <= {shift_reg[WORD_BITS-3:0], serial_in}; // [R1]
        end
    end

    // latch load level checked at the first edge of the frame
    always_ff @(negedge shift_clk) begin
        if (!frame_n && edge_count == '0) begin
            mode_auto <= ~latch_load_n;                         // [R15]
        end
    end

    // ============================================================
    // word hand-off
    // ============================================================
    // on the sixteenth edge keep the last twelve bits, lsb last
    always_ff @(negedge shift_clk) begin
        if (!frame_n && last_edge) begin
            word_hold   <= {shift_reg[CODE_BITS-2:0], serial_in}; // [R14] [R11]
            word_auto   <= (edge_count == '0) ? ~latch_load_n : mode_auto;
        end
    end

    // ready flag: set on the sixteenth edge, cleared while the frame is high
    always_ff @(negedge shift_clk or posedge frame_n) begin
        if (frame_n) begin
            word_toggle <= 1'b0;
        end else if (last_edge) begin
            word_toggle <= 1'b1;                                // [R4]
        end
    end

endmodule : sdp_link_shift

// *** hdl/sdp_port.sv ***
// Purpose: serial input port, converter latch and code format of a 12-bit converter
// Assumes: shift clock from the host is a separate clock domain
// Notes:   registers on classic wishbone, latch output after format conversion
//          0x00 control: bit0 bipolar range, bit1 write one to zero the latch
//          0x04 status: bit0 last frame auto, bit1 word pending, bits 2-4 pins
//          0x08 latch: raw twelve-bit code held for the converter
//          0x0c code: converter code after format conversion
//          unmapped reads return zero, unmapped writes are dropped
//          a write with byte lane zero off leaves the control bits alone
//          the link side has no reset; frame high restarts its gating
//          a clear, pin or bit, wins over any update in the same cycle
//
// Summary of operation
// R1: one 16-bit word, sampled on falling edge
// R2: host uses clock, data and frame only
// R3: automatic or commanded latch update supported
// R4: auto mode updates on sixteenth falling edge
// R5: host pulses latch load low after word
// R6: frame low starts word, high ends it
// R7: host inverts active-high framing strobe
// R8: unipolar format low means natural binary
// R9: bipolar format high means twos complement
// R10: bipolar format low means offset binary
// R11: first four bits ignored, twelve select step
// R12: twos complement maps 800 most negative
// R13: only sixteen edges admitted per frame
// R14: last twelve bits latched, lsb last
// R15: latch load level after frame selects mode
// R16: clear input loads zeros into latch
// R17: latched code output held between updates

`timescale 1ns/100ps

module sdp_port
    import sdp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // serial link
    input  wire logic                 shift_clk,
    input  wire logic                 frame_n,
    input  wire logic                 serial_in,
    // control pins
    input  wire logic                 latch_load_n,
    input  wire logic                 code_format_sel,
    input  wire logic                 zero_latch_n,
    // converter code
    output logic [CODE_BITS-1:0]      dac_code
);

    // ============================================================
    // declarations
    // ============================================================
    logic [CODE_BITS-1:0] link_word;
    logic                 link_auto;
    logic                 link_toggle;

    logic [2:0]           toggle_sync;
    logic [1:0]           load_sync;
    logic [1:0]           format_sync;
    logic [1:0]           zero_sync;
    logic                 load_prev;

    logic                 word_event;
    logic                 load_fall;
    logic                 clear_now;
    logic                 soft_clear;

    logic [CODE_BITS-1:0] dac_latch;
    logic [CODE_BITS-1:0] next_latch;
    logic [CODE_BITS-1:0] next_code;
    logic                 last_auto;
    logic                 bipolar;
    sdp_upd_type          upd_state;
    sdp_upd_type          next_upd_state;

    logic                 bus_req;
    logic                 bus_write;
    logic                 hit_control;
    logic                 hit_status;
    logic                 hit_latch;
    logic                 hit_code;
    logic [31:0]          read_mux;
    logic                 twos_mode;

    // ============================================================
    // link domain
    // ============================================================
    // shift register and gating run on the host shift clock
    // link_toggle is high from the sixteenth edge until the frame ends
    sdp_link_shift u_link (
        .shift_clk    (shift_clk),
        .frame_n      (frame_n),
        .serial_in    (serial_in),
        .latch_load_n (latch_load_n),
        .word_hold    (link_word),
        .word_auto    (link_auto),
        .word_toggle  (link_toggle)
    );

    // ============================================================
    // crossings into the system clock
    // ============================================================
    // the shift clock may stop between frames, so nothing here waits on it
    // ready flag: two stages, third stage for the rising edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            toggle_sync <= 3'b000;
        end else begin
            toggle_sync <= {toggle_sync[1:0], link_toggle};
        end
    end

    // latch load pin: two stages, idle high after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_sync <= 2'b11;
        end else begin
            load_sync <= {load_sync[0], latch_load_n};
        end
    end

    // format pin: two stages, natural binary after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            format_sync <= 2'b00;
        end else begin
            format_sync <= {format_sync[0], code_format_sel};
        end
    end

    // clear pin: two stages, inactive after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            zero_sync <= 2'b11;
        end else begin
            zero_sync <= {zero_sync[0], zero_latch_n};
        end
    end

    // previous latch load level, reset high so no false edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            load_prev <= 1'b1;
        end else begin
            load_prev <= load_sync[1];
        end
    end

    // word event on the rising edge of the crossed ready flag,
    // commanded update on the fall of the synchronised latch load pin
    assign word_event = toggle_sync[1] & ~toggle_sync[2];            // [R4]
    assign load_fall  = load_prev & ~load_sync[1];                   // [R3]
    assign clear_now  = ~zero_sync[1] | soft_clear;                  // [R16]

    // ============================================================
    // update control
    // ============================================================
    // link_word and link_auto stand still from the ready flag onwards,
    // so they are read here only once its rising edge has crossed;
    // a commanded update loads the waiting word once; later latch load falls do nothing until the next word event
    always_comb begin
        next_latch     = dac_latch;
        next_upd_state = upd_state;
        case (upd_state)
            SDP_IDLE: begin
                if (word_event && link_auto) begin
                    next_latch = link_word;                          // [R4] [R3]
                end else if (word_event) begin
                    next_upd_state = SDP_WAITING;                    // [R15]
                end
            end
            SDP_WAITING: begin
                if (word_event && link_auto) begin
                    next_latch     = link_word;                      // [R4]
                    next_upd_state = SDP_IDLE;
                end else if (load_fall) begin
                    next_latch     = link_word;                      // [R15] [R3]
                    next_upd_state = word_event ? SDP_WAITING : SDP_IDLE;
                end
            end
            default: begin
                next_upd_state = SDP_IDLE;
            end
        endcase
        if (clear_now) begin
            next_latch = CODE_ZERO;                                  // [R16]
        end
    end

    // converter latch and update state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_latch <= RST_LATCH;
            upd_state <= SDP_IDLE;
        end else begin
            dac_latch <= next_latch;                                 // [R17]
            upd_state <= next_upd_state;
        end
    end

    // mode of the last completed frame, shown in status
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_auto <= 1'b0;
        end else if (word_event) begin
            last_auto <= link_auto;
        end
    end

    // ============================================================
    // code format
    // ============================================================
    // offset binary is twos complement with the msb flipped, so the
    // converter always receives straight binary
    // unipolar and offset binary pass through, twos complement flips msb
    assign twos_mode = bipolar & format_sync[1];                     // [R9]
    assign next_code = twos_mode ? (dac_latch ^ CODE_MSB_FLIP)       // [R12] [R9]
                                 : dac_latch;                        // [R8] [R10] [R11]

    // registered output, steady while the latch, the bipolar bit and the format pin hold
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_code <= RST_LATCH;
        end else begin
            dac_code <= next_code;                                   // [R17]
        end
    end

    // ============================================================
    // wishbone slave
    // ============================================================
    // request decode
    assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_write   = bus_req & wb_we_i;
    assign hit_control = (wb_adr_i == ADDR_CONTROL);
    assign hit_status  = (wb_adr_i == ADDR_STATUS);
    assign hit_latch   = (wb_adr_i == ADDR_LATCH);
    assign hit_code    = (wb_adr_i == ADDR_CODE);

    // read data selection, unmapped reads return zero
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_control) begin
            read_mux[CTRL_BIPOLAR] = bipolar;
        end else if (hit_status) begin
            read_mux[STAT_AUTO]    = last_auto;
            read_mux[STAT_PENDING] = (upd_state == SDP_WAITING);
            read_mux[STAT_FORMAT]  = format_sync[1];
            read_mux[STAT_LOAD_N]  = load_sync[1];
            read_mux[STAT_ZERO_N]  = zero_sync[1];
        end else if (hit_latch) begin
            read_mux[CODE_BITS-1:0] = dac_latch;
        end else if (hit_code) begin
            read_mux[CODE_BITS-1:0] = dac_code;
        end
    end

    // ack one cycle after the request, dropped the cycle after
    // the ack itself masks the request, so one strobe gives one ack
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read data captured with the ack
    // and held until the next request
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= read_mux;
        end
    end

    // control register, byte lane zero only
    // the clear bit is a one-cycle strobe and is never stored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bipolar    <= RST_BIPOLAR;
            soft_clear <= 1'b0;
        end else begin
            soft_clear <= bus_write & hit_control & wb_sel_i[0] & wb_dat_i[CTRL_CLEAR];
            if (bus_write && hit_control && wb_sel_i[0]) begin
                bipolar <= wb_dat_i[CTRL_BIPOLAR];
            end
        end
    end

endmodule : sdp_port

// *** bench/sdp_port_assertions.sv ***
// Purpose: port-level assertions of the serial converter input port
// Assumes: bound to sdp_port, system clock domain only
// Notes:   clear is synchronised, hence the settling repetitions
`timescale 1ns/100ps

// ============================================================
// checker
// ============================================================
module sdp_port_assertions
    import sdp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_o,
    input  wire logic                 wb_ack_o,
    input  wire logic                 frame_n,
    input  wire logic                 latch_load_n,
    input  wire logic                 code_format_sel,
    input  wire logic                 zero_latch_n,
    input  wire logic [CODE_BITS-1:0] dac_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // request taken at this edge
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd  = req && !wb_we_i;

    chk_ack_answers:
        assert property (req |=> wb_ack_o) else $error("ack missing after request");
    chk_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_ack_unasked:
        assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
    chk_unmapped_zero:
        assert property (rd && wb_adr_i > ADDR_CODE |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_code_readback:
        assert property (rd && wb_adr_i == ADDR_CODE |=> wb_dat_o == {20'h0, $past(dac_code)})
        else $error("code register differs from output");
    chk_clear_reads:
        assert property (rd && wb_adr_i == ADDR_CONTROL |=> wb_dat_o[31:1] == 31'h0)
        else $error("control upper bits not zero");
    chk_clear_zero:
        assert property ((!zero_latch_n)[*6] |-> dac_code[10:0] == 11'h0)
        else $error("clear did not zero the latch");
    chk_code_holds:
        assert property ((frame_n && latch_load_n && zero_latch_n && !wb_cyc_i
            && $stable(code_format_sel))[*8] |=> $stable(dac_code))
        else $error("code changed without update");
    chk_reset_quiet:
        assert property ($rose(reset_n) |-> !wb_ack_o && dac_code == CODE_ZERO)
        else $error("outputs not quiet after reset");
endmodule : sdp_port_assertions

bind sdp_port sdp_port_assertions i_chk (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .frame_n, .latch_load_n, .code_format_sel,
    .zero_latch_n, .dac_code);

// *** bench/sdp_host_model.sv ***
// Purpose: host serial port model framing one word onto the link
// Assumes: go rises once per word while the model is idle
// Notes:   clock parks high outside frames, 32 ns period
`timescale 1ns/100ps

// ============================================================
// host link model
// ============================================================
module sdp_host_model (
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic [3:0]  extra,
    output logic             shift_clk,
    output logic             frame_n,
    output logic             serial_in,
    output logic             busy
);
    // idle link: clock parked, a short frame pulse gives the gating a start
    initial begin
        shift_clk = 1'b1;
        frame_n   = 1'b0;
        serial_in = 1'b0;
        busy      = 1'b0;
        #1 frame_n = 1'b1;
    end

    // only clock, data and frame are driven onto the link
    always @(posedge go) begin
        busy = 1'b1;
        #3 frame_n = 1'b0; // frame already active low, no inversion
        for (int i = 15; i >= 0; i--) begin
            serial_in = word[i]; // msb first, set before the fall
            #16 shift_clk = 1'b0;
            #16 shift_clk = 1'b1;
        end
        // surplus edges with junk data
        repeat (extra) begin
            serial_in = ~serial_in;
            #16 shift_clk = 1'b0;
            #16 shift_clk = 1'b1;
        end
        #16 frame_n = 1'b1; // frame closes after the word
        serial_in = ~serial_in; // released line shows no stale bit
        #16 busy = 1'b0;
    end
endmodule : sdp_host_model

// *** bench/sdp_port_tb.sv ***
// Purpose: self-checking bench of the serial converter input port
// Assumes: host model drives the link, bench drives pins and bus
// Notes:   random words from an xorshift generator with fixed seed
`timescale 1ns/100ps

// ============================================================
// bench top
// ============================================================
module sdp_port_tb
    import sdp_pkg::*;
;
    logic        clk, reset_n, cyc, stb, we, go, busy, ack, bip;
    logic        shift_clk, frame_n, serial_in, latch_load_n, code_format_sel, zero_latch_n;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, dat_o, seed;
    logic [15:0] word, w;
    logic [3:0]  extra;
    logic [3:0]  sel;
    logic [11:0] dac_code, exp_c;
    logic [15:0] corner [4] = '{16'h0fff, 16'hf000, 16'h0800, 16'h07ff};
    logic [7:0]  zero_adr [3] = '{ADDR_CONTROL, ADDR_CODE, 8'h10};
    int          n_fail, n_compared;

    sdp_port i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .shift_clk(shift_clk), .frame_n(frame_n), .serial_in(serial_in),
        .latch_load_n(latch_load_n), .code_format_sel(code_format_sel),
        .zero_latch_n(zero_latch_n), .dac_code(dac_code));
    sdp_host_model i_host (.go(go), .word(word), .extra(extra), .shift_clk(shift_clk),
        .frame_n(frame_n), .serial_in(serial_in), .busy(busy));

    // system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // bounded wait for a level, a miss ends the run
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== v && n < lim);
        if (s !== v) begin
            n_fail++;
            report_and_stop();
        end
    endtask : wait_for

    // one classic wishbone cycle
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        wait_for(ack, 1'b1, 20);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic send(input logic [15:0] v, input logic [3:0] x);
        word <= v;
        extra <= x;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait_for(busy, 1'b0, 400);
        repeat (8) @(posedge clk);
    endtask : send

    task automatic expect_word(input logic [15:0] v);
        exp_c = (bip & code_format_sel) ? v[11:0] ^ 12'h800 : v[11:0];
        check("dac_code", {20'h0, dac_code}, {20'h0, exp_c});
        bus(1'b0, ADDR_LATCH, 32'h0);
        check("latch", rdat, {20'h0, v[11:0]});
    endtask : expect_word

    initial begin
        {reset_n, cyc, stb, we, go, adr, wdat, word, extra, bip} = '0;
        sel = 4'h1;
        {latch_load_n, code_format_sel, zero_latch_n} = 3'b001;
        seed = 32'h7515;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        foreach (zero_adr[k]) begin
            bus(1'b0, zero_adr[k], 32'h0);
            check("reset_read", rdat, 32'h0);
        end
        $display("test reset done");
        // auto update over every range and format, surplus edges at random
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            bip = i[1];
            code_format_sel <= i[0];
            bus(1'b1, ADDR_CONTROL, {31'h0, bip});
            w = (i < 4) ? corner[i] : seed[15:0];
            send(w, seed[19:16]);
            expect_word(w);
        end
        $display("test auto done");
        // deferred update waits for the latch load fall
        latch_load_n <= 1'b1;
        repeat (2) @(posedge clk);
        send(16'h0a5c, 4'h0);
        check("deferred", {20'h0, dac_code}, {20'h0, exp_c});
        bus(1'b0, ADDR_STATUS, 32'h0);
        check("status", rdat, {27'h0, zero_latch_n, latch_load_n, code_format_sel, 2'b10});
        latch_load_n <= 1'b0;
        repeat (4) @(posedge clk);
        latch_load_n <= 1'b1;
        repeat (8) @(posedge clk);
        expect_word(16'h0a5c);
        latch_load_n <= 1'b0;
        $display("test deferred done");
        // clear pin and clear bit
        zero_latch_n <= 1'b0;
        repeat (8) @(posedge clk);
        exp_c = (bip & code_format_sel) ? 12'h800 : 12'h000;
        check("clear_pin", {20'h0, dac_code}, {20'h0, exp_c});
        zero_latch_n <= 1'b1;
        send(16'h0123, 4'h0);
        sel <= 4'h0;
        bus(1'b1, ADDR_CONTROL, {30'h0, 1'b1, ~bip});
        sel <= 4'h1;
        bus(1'b0, ADDR_CONTROL, 32'h0);
        check("lane_off", rdat, {31'h0, bip});
        expect_word(16'h0123);
        bus(1'b1, ADDR_CONTROL, {30'h0, 1'b1, bip});
        repeat (4) @(posedge clk);
        exp_c = (bip & code_format_sel) ? 12'h800 : 12'h000;
        check("clear_bit", {20'h0, dac_code}, {20'h0, exp_c});
        bus(1'b0, ADDR_LATCH, 32'h0);
        check("clear_latch", rdat, 32'h0);
        $display("test clear done");
        report_and_stop();
    end
endmodule : sdp_port_tb
